// ### alarm_autoreset_cfg.svh
`ifndef ALARM_AUTORESET_CFG_SVH
`define ALARM_AUTORESET_CFG_SVH
// parameter offsets in the device's parameter space
`define OFS_ATTEMPT_LIMIT 16'h04E7
`define OFS_CLEAR_TIME    16'h04E8
`define OFS_PON_CLEAR     16'h04E9
`define OFS_KEEP_SUPPLY   16'h04EA
// reset values
`define RST_ATTEMPT_LIMIT 16'h0000
`define RST_CLEAR_TIME    16'h012C
`define RST_PON_CLEAR     1'h0
`define RST_KEEP_SUPPLY   1'h0
// upper limits of the settings
`define MAX_ATTEMPT_LIMIT 16'h0064
`define MAX_CLEAR_TIME    16'h03E8
// alarm codes of the supply alarms
`define CODE_UNDERVOLTAGE 16'h002F
`define CODE_MAINS_LOSS   16'h0040
// field position of one-bit settings
`define FLAG_BIT          0
// time base
`define TICK_PERIOD_S     1
`define CLK_HZ            100000000
`define TICK_CYCLES       (`TICK_PERIOD_S * `CLK_HZ)
`endif

// ### alarm_autoreset_checker.sv
`timescale 1ns/100ps
`default_nettype none
module alarm_autoreset_checker
	import alarm_autoreset_pkg::*;
#(parameter int CNT_W = 8) (
	// watched ports
	input wire logic             clk_in,
	input wire logic             nrst_in,
	input wire par_req_t         par_req_in,
	input wire logic             par_rvalid_out,
	input wire logic             alarm_trip_in,
	input wire logic [15:0]      alarm_code_in,
	input wire logic             motor_running_in,
	input wire logic             dc_bus_low_in,
	input wire logic             power_fail_in,
	input wire logic             nvm_write_out,
	input wire alarm_rec_t       alarm_out,
	input wire logic             autoreset_out,
	input wire logic [CNT_W-1:0] attempt_count_out,
	input wire logic             blocked_out
);
	// one domain, so clock and reset are given once
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	// parameter reads answer one cycle later, and only then
	property p_rd; par_req_in.rd |=> par_rvalid_out; endproperty
	a_rd: assert property (p_rd) else $error("read not answered");
	property p_rv; par_rvalid_out |-> $past(par_req_in.rd); endproperty
	a_rv: assert property (p_rv) else $error("stray read answer");
	// a trip shows its code next cycle
	property p_trip; alarm_trip_in && !alarm_out.valid |=>
		alarm_out.valid && alarm_out.code == $past(alarm_code_in); endproperty
	a_trip: assert property (p_trip) else $error("trip not shown");
	// once blocked a standing alarm is never auto-reset
	property p_blk; blocked_out && alarm_out.valid |=> !autoreset_out; endproperty
	a_blk: assert property (p_blk) else $error("reset while blocked");
	// the count only steps up with a reset or drops to zero
	property p_cnt; attempt_count_out != $past(attempt_count_out) |->
		attempt_count_out == '0 ||
		(autoreset_out && attempt_count_out == $past(attempt_count_out) + 1'b1);
	endproperty
	a_cnt: assert property (p_cnt) else $error("count jumped");
	property p_ar; autoreset_out |=> !autoreset_out; endproperty
	a_ar: assert property (p_ar) else $error("reset pulse too long");
	// pin delay covers the synchroniser plus edge register
	property p_uv; $rose(dc_bus_low_in) && motor_running_in && !alarm_out.valid
		|-> ##[1:8] (alarm_out.valid && alarm_out.code == 16'h002F); endproperty
	a_uv: assert property (p_uv) else $error("undervoltage missed");
	property p_nvm; $rose(power_fail_in) |-> ##[1:8] nvm_write_out; endproperty
	a_nvm: assert property (p_nvm) else $error("no store at power-off");
endmodule : alarm_autoreset_checker
bind alarm_autoreset_controller alarm_autoreset_checker #(.CNT_W(CNT_W)) chk_i (
	.clk_in            (clk_in),
	.nrst_in           (nrst_in),
	.par_req_in        (par_req_in),
	.par_rvalid_out    (par_rvalid_out),
	.alarm_trip_in     (alarm_trip_in),
	.alarm_code_in     (alarm_code_in),
	.motor_running_in  (motor_running_in),
	.dc_bus_low_in     (dc_bus_low_in),
	.power_fail_in     (power_fail_in),
	.nvm_write_out     (nvm_write_out),
	.alarm_out         (alarm_out),
	.autoreset_out     (autoreset_out),
	.attempt_count_out (attempt_count_out),
	.blocked_out       (blocked_out)
);
`default_nettype wire

// ### alarm_autoreset_controller.sv
`timescale 1ns/100ps
`default_nettype none
`include "alarm_autoreset_cfg.svh"

module alarm_autoreset_controller
	import alarm_autoreset_pkg::*;
#(
	parameter int TICK_CYCLES = `TICK_CYCLES,
	parameter int CNT_W       = 8
) (
	// clock and reset
	input  wire logic             clk_in,
	input  wire logic             nrst_in,
	// parameter access
	input  wire par_req_t         par_req_in,
	output logic [15:0]           par_rdata_out,
	output logic                  par_rvalid_out,
	// alarm sources and operator clear
	input  wire logic             alarm_trip_in,
	input  wire logic [15:0]      alarm_code_in,
	input  wire logic             alarm_clear_in,
	input  wire logic             motor_running_in,
	input  wire logic             power_down_en_in,
	// supply monitor pins
	input  wire logic             dc_bus_low_in,
	input  wire logic             mains_lost_in,
	input  wire logic             power_fail_in,
	// non-volatile storage
	input  wire logic             params_ready_in,
	input  wire alarm_rec_t       nvm_rec_in,
	output logic                  nvm_write_out,
	output alarm_rec_t            nvm_rec_out,
	// alarm state
	output alarm_rec_t            alarm_out,
	output logic                  autoreset_out,
	output logic [CNT_W-1:0]      attempt_count_out,
	output logic                  blocked_out,
	output logic                  undervoltage_alarm_out,
	output logic                  mains_loss_alarm_out
);
	localparam int TW = $clog2(TICK_CYCLES + 1);

	// reset release synchroniser
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			rst_meta <= 1'b0;
			rst_n    <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n    <= rst_meta;
		end
	end

	// pin synchronisers: 0 dc bus low, 1 mains lost, 2 power fail
	logic [2:0] pin_raw;
	logic [2:0] pin_meta;
	logic [2:0] pin_sync;
	logic [2:0] pin_prev;
	logic [2:0] pin_rise;
	assign pin_raw = {power_fail_in, mains_lost_in, dc_bus_low_in};
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_sync
			always_ff @(posedge clk_in or negedge rst_n) begin
				if (!rst_n) begin
					pin_meta[gi] <= 1'b0;
					pin_sync[gi] <= 1'b0;
					pin_prev[gi] <= 1'b0;
				end else begin
					pin_meta[gi] <= pin_raw[gi];
					pin_sync[gi] <= pin_meta[gi];
					pin_prev[gi] <= pin_sync[gi];
				end
			end
			assign pin_rise[gi] = pin_sync[gi] & ~pin_prev[gi];
		end
	endgenerate

	// one-second enable pulse; the divider is a parameter so a bench can shorten it
	logic [TW-1:0] tick_cnt;
	logic [TW-1:0] next_tick_cnt;
	logic          sec_tick;
	logic          next_sec_tick;
	always_comb begin
		next_tick_cnt = tick_cnt + TW'(1);
		next_sec_tick = 1'b0;
		if (tick_cnt == TW'(TICK_CYCLES - 1)) begin
			next_tick_cnt = '0;
			next_sec_tick = 1'b1;
		end
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			tick_cnt <= '0;
			sec_tick <= 1'b0;
		end else begin
			tick_cnt <= next_tick_cnt;
			sec_tick <= next_sec_tick;
		end
	end

	// settings; out-of-range limit and clear-time writes clamp to the top of the range
	logic [15:0] attempt_limit;
	logic [15:0] clear_time;
	logic        pon_clear;
	logic        keep_supply;
	logic [15:0] rdata;
	logic        rvalid;
	logic [15:0] next_attempt_limit;
	logic [15:0] next_clear_time;
	logic        next_pon_clear;
	logic        next_keep_supply;
	logic [15:0] next_rdata;
	logic        next_rvalid;
	always_comb begin
		next_attempt_limit = attempt_limit;
		next_clear_time    = clear_time;
		next_pon_clear     = pon_clear;
		next_keep_supply   = keep_supply;
		next_rvalid        = par_req_in.rd;
		next_rdata         = rdata;
		if (par_req_in.wr) begin
			case (par_req_in.addr)
				`OFS_ATTEMPT_LIMIT: begin
					next_attempt_limit = (par_req_in.data > `MAX_ATTEMPT_LIMIT) ?
						`MAX_ATTEMPT_LIMIT : par_req_in.data;
				end
				`OFS_CLEAR_TIME: begin
					next_clear_time = (par_req_in.data > `MAX_CLEAR_TIME) ?
						`MAX_CLEAR_TIME : par_req_in.data;
				end
				`OFS_PON_CLEAR: next_pon_clear = par_req_in.data[`FLAG_BIT];
				`OFS_KEEP_SUPPLY: next_keep_supply = par_req_in.data[`FLAG_BIT];
				default: ;
			endcase
		end
		// unmapped addresses read as zero
		if (par_req_in.rd) begin
			case (par_req_in.addr)
				`OFS_ATTEMPT_LIMIT: next_rdata = attempt_limit;
				`OFS_CLEAR_TIME:    next_rdata = clear_time;
				`OFS_PON_CLEAR:     next_rdata = {15'h0000, pon_clear};
				`OFS_KEEP_SUPPLY:   next_rdata = {15'h0000, keep_supply};
				default:            next_rdata = 16'h0000;
			endcase
		end
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			attempt_limit <= `RST_ATTEMPT_LIMIT;
			clear_time    <= `RST_CLEAR_TIME;
			pon_clear     <= `RST_PON_CLEAR;
			keep_supply   <= `RST_KEEP_SUPPLY;
			rdata         <= 16'h0000;
			rvalid        <= 1'b0;
		end else begin
			attempt_limit <= next_attempt_limit;
			clear_time    <= next_clear_time;
			pon_clear     <= next_pon_clear;
			keep_supply   <= next_keep_supply;
			rdata         <= next_rdata;
			rvalid        <= next_rvalid;
		end
	end
	assign par_rdata_out  = rdata;
	assign par_rvalid_out = rvalid;

	// alarm sources: supply alarms trip on the edge of their condition
	logic        uv_evt;
	logic        ml_evt;
	logic        src_valid;
	logic [15:0] src_code;
	assign uv_evt    = pin_rise[0] & motor_running_in;
	assign ml_evt    = pin_rise[1] & motor_running_in & ~power_down_en_in;
	assign src_valid = alarm_trip_in | uv_evt | ml_evt;
	// external alarms take priority over the supply alarms
	assign src_code  = alarm_trip_in ? alarm_code_in :
		(uv_evt ? `CODE_UNDERVOLTAGE : `CODE_MAINS_LOSS);

	// core state
	boot_state_t      state;
	boot_state_t      next_state;
	alarm_rec_t       alarm;
	alarm_rec_t       next_alarm;
	alarm_rec_t       nvm_rec;
	alarm_rec_t       next_nvm_rec;
	logic             pending;
	logic             next_pending;
	logic [CNT_W-1:0] count;
	logic [CNT_W-1:0] next_count;
	logic [15:0]      secs;
	logic [15:0]      next_secs;
	logic             arst;
	logic             next_arst;
	logic             nvm_wr;
	logic             next_nvm_wr;
	logic             uv_out;
	logic             next_uv_out;
	logic             ml_out;
	logic             next_ml_out;
	logic             blocked;
	logic             next_blocked;
	logic             is_supply;
	assign is_supply = (alarm.code == `CODE_UNDERVOLTAGE) || (alarm.code == `CODE_MAINS_LOSS);

	// trip, auto-reset, attempt counting and power-fail storage
	always_comb begin
		next_state   = state;
		next_alarm   = alarm;
		next_nvm_rec = nvm_rec;
		next_pending = pending;
		next_count   = count;
		next_secs    = secs;
		next_arst    = 1'b0;
		next_nvm_wr  = 1'b0;
		case (state)
			BOOT_WAIT: begin
				// settings must be restored before the stored alarm is judged
				if (params_ready_in) begin
					next_state = BOOT_RUN;
					if (nvm_rec_in.valid) begin
						if (pon_clear) begin
							next_arst = 1'b1;
						end else begin
							next_alarm = nvm_rec_in;
						end
					end
				end
			end
			BOOT_RUN: begin
				// seconds since last trip, saturating at the largest clear time
				if (sec_tick && (secs < `MAX_CLEAR_TIME)) begin
					next_secs = secs + 16'h0001;
				end
				if ((count != '0) && (secs >= clear_time)) begin
					next_count = '0;
				end
				if (pending) begin
					next_alarm.valid = 1'b0;
					next_arst        = 1'b1;
					next_count       = next_count + CNT_W'(1);
					next_pending     = 1'b0;
				end
				if (alarm_clear_in) begin
					next_alarm.valid = 1'b0;
					next_pending     = 1'b0;
				end
				// a trip is taken only while no alarm stands; it wins over a same-cycle clear
				if (src_valid && !alarm.valid) begin
					next_alarm.valid = 1'b1;
					next_alarm.code  = src_code;
					next_secs        = 16'h0000;
					next_pending     = (attempt_limit != 16'h0000) &&
						({{(16-CNT_W){1'b0}}, next_count} < attempt_limit);
				end
			end
			default: next_state = BOOT_WAIT;
		endcase
		// power failing: store the standing alarm, or clear the store
		if (pin_rise[2]) begin
			next_nvm_wr        = 1'b1;
			next_nvm_rec.code  = alarm.code;
			next_nvm_rec.valid = alarm.valid && (keep_supply || !is_supply);
		end
		next_uv_out = next_alarm.valid && (next_alarm.code == `CODE_UNDERVOLTAGE);
		next_ml_out = next_alarm.valid && (next_alarm.code == `CODE_MAINS_LOSS);
		// status comes from a flop, so it follows the next limit and count; limit zero never blocks
		next_blocked = (next_attempt_limit != 16'h0000) &&
			({{(16-CNT_W){1'b0}}, next_count} >= next_attempt_limit);
	end
	always_ff @(posedge clk_in or negedge rst_n) begin
		if (!rst_n) begin
			state   <= BOOT_WAIT;
			alarm   <= '0;
			nvm_rec <= '0;
			pending <= 1'b0;
			count   <= '0;
			secs    <= 16'h0000;
			arst    <= 1'b0;
			nvm_wr  <= 1'b0;
			uv_out  <= 1'b0;
			ml_out  <= 1'b0;
			blocked <= 1'b0;
		end else begin
			state   <= next_state;
			alarm   <= next_alarm;
			nvm_rec <= next_nvm_rec;
			pending <= next_pending;
			count   <= next_count;
			secs    <= next_secs;
			arst    <= next_arst;
			nvm_wr  <= next_nvm_wr;
			uv_out  <= next_uv_out;
			ml_out  <= next_ml_out;
			blocked <= next_blocked;
		end
	end

	// outputs
	assign alarm_out              = alarm;
	assign autoreset_out          = arst;
	assign attempt_count_out      = count;
	assign nvm_write_out          = nvm_wr;
	assign nvm_rec_out            = nvm_rec;
	assign undervoltage_alarm_out = uv_out;
	assign mains_loss_alarm_out   = ml_out;
	assign blocked_out            = blocked;
endmodule : alarm_autoreset_controller
`default_nettype wire

// ### alarm_autoreset_controller_bench.sv
`timescale 1ns/100ps
`default_nettype none
module alarm_autoreset_controller_bench;
	import alarm_autoreset_pkg::*;
	logic       clk_in, nrst_in, par_rvalid_out, alarm_trip_in, alarm_clear_in;
	logic       motor_running_in, power_down_en_in, dc_bus_low_in, mains_lost_in;
	logic       power_fail_in, params_ready_in, nvm_write_out, autoreset_out;
	logic       blocked_out, undervoltage_alarm_out, mains_loss_alarm_out;
	logic [15:0] par_rdata_out, alarm_code_in, rnd, v;
	logic [7:0] attempt_count_out;
	par_req_t   par_req_in;
	alarm_rec_t nvm_rec_in, nvm_rec_out, alarm_out;
	int         num_errors, cmp_count;
	// short tick keeps the count-clear waits within a few hundred cycles
	alarm_autoreset_controller #(.TICK_CYCLES(20)) dut (
		.clk_in                 (clk_in),
		.nrst_in                (nrst_in),
		.par_req_in             (par_req_in),
		.par_rdata_out          (par_rdata_out),
		.par_rvalid_out         (par_rvalid_out),
		.alarm_trip_in          (alarm_trip_in),
		.alarm_code_in          (alarm_code_in),
		.alarm_clear_in         (alarm_clear_in),
		.motor_running_in       (motor_running_in),
		.power_down_en_in       (power_down_en_in),
		.dc_bus_low_in          (dc_bus_low_in),
		.mains_lost_in          (mains_lost_in),
		.power_fail_in          (power_fail_in),
		.params_ready_in        (params_ready_in),
		.nvm_rec_in             (nvm_rec_in),
		.nvm_write_out          (nvm_write_out),
		.nvm_rec_out            (nvm_rec_out),
		.alarm_out              (alarm_out),
		.autoreset_out          (autoreset_out),
		.attempt_count_out      (attempt_count_out),
		.blocked_out            (blocked_out),
		.undervoltage_alarm_out (undervoltage_alarm_out),
		.mains_loss_alarm_out   (mains_loss_alarm_out)
	);
	// 100 MHz clock
	initial begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction : lfsr
	function automatic logic [15:0] clamp(input logic [15:0] x, m);
		return (x > m) ? m : x;
	endfunction : clamp
	// wide enough for a flag in front of a full alarm record
	task automatic chk(input logic [31:0] seen, exp);
		cmp_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : tally_and_finish
	task automatic wr(input logic [15:0] a, d);
		@(posedge clk_in) par_req_in <= '{1'b1, 1'b0, a, d};
		@(posedge clk_in) par_req_in <= '0;
	endtask : wr
	task automatic rd(input logic [15:0] a, exp);
		@(posedge clk_in) par_req_in <= '{1'b0, 1'b1, a, 16'h0000};
		@(posedge clk_in) par_req_in <= '0;
		#1 chk({par_rvalid_out, par_rdata_out}, {1'b1, exp});
	endtask : rd
	task automatic trip(input logic [15:0] c);
		@(posedge clk_in) begin
			alarm_trip_in <= 1'b1;
			alarm_code_in <= c;
		end
		@(posedge clk_in) alarm_trip_in <= 1'b0;
		#1 chk(alarm_out, {1'b1, c});
	endtask : trip
	task automatic clr;
		@(posedge clk_in) alarm_clear_in <= 1'b1;
		@(posedge clk_in) alarm_clear_in <= 1'b0;
		@(posedge clk_in) #1 chk(alarm_out.valid, 1'b0);
	endtask : clr
	// reset is taken at the edge, then the boot waits for settings
	task automatic do_reset;
		@(posedge clk_in) begin
			nrst_in <= 1'b0;
			params_ready_in <= 1'b0;
		end
		repeat (4) @(posedge clk_in);
		nrst_in <= 1'b1;
		repeat (3) @(posedge clk_in);
	endtask : do_reset
	// power-off store, then a bounded wait for the write pulse
	task automatic pf(input logic ok, input logic [15:0] c);
		@(posedge clk_in) power_fail_in <= 1'b1;
		for (int k = 0; k < 10 && nvm_write_out !== 1'b1; k++) @(posedge clk_in) #1;
		chk(nvm_rec_out, {ok, c});
		@(posedge clk_in) power_fail_in <= 1'b0;
	endtask : pf
	task automatic wait_alarm;
		for (int k = 0; k < 10 && alarm_out.valid !== 1'b1; k++) @(posedge clk_in) #1;
		@(posedge clk_in) #1;
	endtask : wait_alarm
	// hang guard
	initial begin
		#200000;
		num_errors++;
		tally_and_finish();
	end
	// main sequence
	initial begin
		{nrst_in, alarm_trip_in, alarm_clear_in, power_down_en_in} = '0;
		{dc_bus_low_in, mains_lost_in, power_fail_in, params_ready_in} = '0;
		par_req_in = '0;
		alarm_code_in = '0;
		motor_running_in = 1'b1;
		nvm_rec_in = '{1'b1, 16'h0055};
		{num_errors, cmp_count} = '0;
		rnd = 16'hBA85;
		do_reset();
		rd(16'h04E7, 16'h0000);
		rd(16'h04E8, 16'h012C);
		rd(16'h04E9, 16'h0000);
		rd(16'h04EA, 16'h0000);
		rd(16'h04EB, 16'h0000);
		@(posedge clk_in) params_ready_in <= 1'b1;
		repeat (3) @(posedge clk_in);
		#1 chk(alarm_out, {1'b1, 16'h0055});
		clr();
		do_reset();
		wr(16'h04E9, 16'h0001);
		@(posedge clk_in) params_ready_in <= 1'b1;
		// ready is taken one edge later, and the reset pulse stands for one cycle only
		@(posedge clk_in) #1 chk({autoreset_out, alarm_out.valid}, 2'b10);
		// boundary values first, then random ones
		for (int i = 0; i < 10; i++) begin
			rnd = lfsr(rnd);
			v = (i < 4) ? 16'h0064 + 16'(i) + ((i > 1) ? 16'h0382 : 16'h0000) : rnd;
			wr(16'h04E7, v);
			rd(16'h04E7, clamp(v, 16'h0064));
			wr(16'h04E8, v);
			rd(16'h04E8, clamp(v, 16'h03E8));
			wr(16'h04EA, v);
			rd(16'h04EA, {15'h0, v[0]});
		end
		wr(16'h04E7, 16'h0002);
		wr(16'h04E8, 16'h03E8);
		wr(16'h04EA, 16'h0000);
		for (int i = 1; i <= 3; i++) begin
			trip(16'h0005 + 16'(i));
			@(posedge clk_in) #1;
			chk({autoreset_out, alarm_out.valid, attempt_count_out},
				(i < 3) ? {2'b10, 8'(i)} : {2'b01, 8'h02});
		end
		chk(blocked_out, 1'b1);
		clr();
		wr(16'h04E8, 16'h0003);
		// at most one second has passed since the last trip, so the count still stands
		#1 chk(attempt_count_out, 8'h02);
		for (int k = 0; k < 200 && attempt_count_out !== 8'h00; k++) @(posedge clk_in) #1;
		chk({blocked_out, attempt_count_out}, 9'h000);
		wr(16'h04E7, 16'h0000);
		trip(16'h0009);
		@(posedge clk_in) #1 chk({autoreset_out, alarm_out.valid}, 2'b01);
		clr();
		@(posedge clk_in) dc_bus_low_in <= 1'b1;
		wait_alarm();
		chk({undervoltage_alarm_out, alarm_out}, {2'b11, 16'h002F});
		pf(1'b0, 16'h002F);
		wr(16'h04EA, 16'h0001);
		pf(1'b1, 16'h002F);
		dc_bus_low_in <= 1'b0;
		clr();
		@(posedge clk_in) mains_lost_in <= 1'b1;
		wait_alarm();
		chk({mains_loss_alarm_out, alarm_out}, {2'b11, 16'h0040});
		clr();
		// let the synchronised pin settle low before the next rise
		@(posedge clk_in) begin
			mains_lost_in    <= 1'b0;
			power_down_en_in <= 1'b1;
		end
		repeat (3) @(posedge clk_in);
		mains_lost_in <= 1'b1;
		wait_alarm();
		chk(alarm_out.valid, 1'b0);
		// a low bus while the motor stands is no undervoltage trip
		@(posedge clk_in) begin
			motor_running_in <= 1'b0;
			dc_bus_low_in    <= 1'b1;
		end
		wait_alarm();
		chk(alarm_out.valid, 1'b0);
		tally_and_finish();
	end
endmodule : alarm_autoreset_controller_bench
`default_nettype wire

// ### alarm_autoreset_pkg.sv
`default_nettype none
package alarm_autoreset_pkg;
	// parameter access request
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] addr;
		logic [15:0] data;
	} par_req_t;
	// alarm record, as held live and in non-volatile storage
	typedef struct packed {
		logic        valid;
		logic [15:0] code;
	} alarm_rec_t;
	// power-on sequencing
	typedef enum logic [0:0] {
		BOOT_WAIT,
		BOOT_RUN
	} boot_state_t;
endpackage : alarm_autoreset_pkg
`default_nettype wire

// ### alarm_autoreset_pkg_order_note_unused.sv
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire
